// ### common/pcg_pkg.sv
package pcg_pkg;
   // ---------------------------------------------------------------
   // register map: word index, byte address is four times it
   // ---------------------------------------------------------------
   localparam int PCG_PORT_WIDTH = 8;
   localparam int PCG_IDX_LATCH = 2;
   localparam int PCG_IDX_DIR = 1;
   localparam int PCG_IDX_PULLDOWN = 3;
   localparam logic [11:0] PCG_OFF_LATCH = 12'(PCG_IDX_LATCH * 4);
   localparam logic [11:0] PCG_OFF_DIR = 12'(PCG_IDX_DIR * 4);
   localparam logic [11:0] PCG_OFF_PULLDOWN = 12'(PCG_IDX_PULLDOWN * 4);
   // ---------------------------------------------------------------
   // field positions, reset values, fixed read value and AHB transfer codes
   // ---------------------------------------------------------------
   localparam int PCG_LOWER_INH_BIT = 0;
   localparam int PCG_UPPER_INH_BIT = 1;
   localparam logic [7:0] PCG_DIR_RESET = 8'h00;
   localparam logic [1:0] PCG_INH_RESET = 2'h0;
   localparam logic [31:0] PCG_UNDEF_READ = 32'h00000000;
   localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PCG_HTRANS_SEQ = 2'h3;
endpackage : pcg_pkg

// ### design/pcg_sync.sv
`timescale 1ns/10ps
module pcg_sync
   import pcg_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } pcg_sync_state_t;
   pcg_sync_state_t s_q;
   pcg_sync_state_t s_d;

   always_comb begin
      s_d.meta = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;
endmodule : pcg_sync

// ### design/pcg_pad_ctl.sv
`timescale 1ns/10ps
module pcg_pad_ctl
   import pcg_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] dir,
   input wire logic [WIDTH-1:0] latch,
   input wire logic [1:0] nibble_inhibit,
   input wire logic mask_inhibit,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pulldown_en
);
   always_comb begin
      pin_out = latch;
      pin_oe = dir;
      for (int i = 0; i < WIDTH; i++) begin
         // upper half follows upper inhibit bit
         pulldown_en[i] = !mask_inhibit && !dir[i] &&
            !nibble_inhibit[(i >= WIDTH/2) ? PCG_UPPER_INH_BIT
                                           : PCG_LOWER_INH_BIT];
      end
   end
endmodule : pcg_pad_ctl

// ### design/pcg_port.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module pcg_port
   import pcg_pkg::*;
#(
   parameter int WIDTH = PCG_PORT_WIDTH
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic mask_pulldown_inhibit,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pulldown_en
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // latch sits apart: it has no reset at all, so it keeps its value
   typedef struct packed {
      logic [WIDTH-1:0] dir;
      logic [1:0] inhibit;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
   } pcg_state_t;
   pcg_state_t s_q;
   pcg_state_t s_d;
   logic [WIDTH-1:0] latch_q;
   logic [WIDTH-1:0] latch_d;
   logic [WIDTH-1:0] pin_sync;
   logic addr_valid;
   logic [WIDTH-1:0] port_view;

   function automatic logic [31:0] pcg_widen(input logic [WIDTH-1:0] v);
      pcg_widen = 32'h00000000;
      pcg_widen[WIDTH-1:0] = v;
   endfunction : pcg_widen

   pcg_sync #(.WIDTH(WIDTH)) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ---------------------------------------------------------------
   // bus slave: zero wait states, writes land at end of data phase
   // ---------------------------------------------------------------
   assign addr_valid = hsel && hready &&
      (htrans == PCG_HTRANS_NONSEQ || htrans == PCG_HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   // per-bit select between latch and pin
   assign port_view = (s_q.dir & latch_q) | (~s_q.dir & pin_sync);

   always_comb begin
      s_d = s_q;
      latch_d = latch_q;
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            PCG_OFF_LATCH: begin
               latch_d = hwdata[WIDTH-1:0];
            end
            PCG_OFF_DIR: begin
               s_d.dir = hwdata[WIDTH-1:0];
            end
            PCG_OFF_PULLDOWN: begin
               // the mask option freezes software control
               if (!mask_pulldown_inhibit) begin
                  s_d.inhibit = hwdata[1:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (addr_valid) begin
         s_d.wr_pend = hwrite;
         s_d.wr_addr = haddr;
         if (!hwrite) begin
            case (haddr)
               PCG_OFF_LATCH: s_d.rdata = pcg_widen(port_view);
               PCG_OFF_DIR: s_d.rdata = pcg_widen(s_q.dir);
               // write-only: reads give a fixed don't-care value
               PCG_OFF_PULLDOWN: s_d.rdata = PCG_UNDEF_READ;
               default: s_d.rdata = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.dir <= PCG_DIR_RESET;
         s_q.inhibit <= PCG_INH_RESET;
         s_q.wr_pend <= 1'b0;
         s_q.wr_addr <= 12'h000;
         s_q.rdata <= 32'h00000000;
      end else begin
         s_q <= s_d;
      end
   end

   // no reset term: contents survive reset
   always_ff @(posedge ref_clk) begin
      latch_q <= latch_d;
   end

   pcg_pad_ctl #(.WIDTH(WIDTH)) u_pad (
      .dir(s_q.dir),
      .latch(latch_q),
      .nibble_inhibit(s_q.inhibit),
      .mask_inhibit(mask_pulldown_inhibit),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .pulldown_en(pulldown_en)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_reset_dir;
      @(posedge ref_clk) $rose(reset_n) |-> (pin_oe == '0);
   endproperty
   a_reset_dir: assert property (p_reset_dir)
      else $error("direction not cleared by reset");

   property p_oe_dir;
      @(posedge ref_clk) disable iff (!reset_n) pin_oe == s_q.dir;
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("output enable differs from direction");

   property p_drive;
      @(posedge ref_clk) disable iff (!reset_n)
         ((pin_out & pin_oe) == (latch_q & s_q.dir));
   endproperty
   a_drive: assert property (p_drive)
      else $error("driven pin not from latch");

   property p_pd_off_out;
      @(posedge ref_clk) disable iff (!reset_n) (pulldown_en & pin_oe) == '0;
   endproperty
   a_pd_off_out: assert property (p_pd_off_out)
      else $error("pulldown on with output");

   property p_mask;
      @(posedge ref_clk) disable iff (!reset_n)
         mask_pulldown_inhibit |-> pulldown_en == '0;
   endproperty
   a_mask: assert property (p_mask)
      else $error("pulldown on under mask option");

   property p_dir_write;
      @(posedge ref_clk) disable iff (!reset_n)
         (s_q.wr_pend && s_q.wr_addr == PCG_OFF_DIR)
            |=> s_q.dir == $past(hwdata[WIDTH-1:0]);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write lost");

   property p_latch_write;
      @(posedge ref_clk) disable iff (!reset_n)
         (s_q.wr_pend && s_q.wr_addr == PCG_OFF_LATCH)
            |=> latch_q == $past(hwdata[WIDTH-1:0]);
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("latch write lost");

   property p_read_port;
      @(posedge ref_clk) disable iff (!reset_n)
         (addr_valid && !hwrite && haddr == PCG_OFF_LATCH)
            |=> hrdata[WIDTH-1:0] ==
               (($past(s_q.dir) & $past(latch_q)) |
                (~$past(s_q.dir) & $past(pin_sync)));
   endproperty
   a_read_port: assert property (p_read_port)
      else $error("port read value wrong");

   property p_nibble;
      @(posedge ref_clk) disable iff (!reset_n)
         (!mask_pulldown_inhibit && s_q.inhibit[PCG_UPPER_INH_BIT] == 1'b0)
            |-> pulldown_en[WIDTH-1:WIDTH/2] == ~s_q.dir[WIDTH-1:WIDTH/2];
   endproperty
   a_nibble: assert property (p_nibble)
      else $error("upper pulldown mismatch");

   property p_nibble_lo;
      @(posedge ref_clk) disable iff (!reset_n)
         (!mask_pulldown_inhibit && s_q.inhibit[PCG_LOWER_INH_BIT] == 1'b0)
            |-> pulldown_en[WIDTH/2-1:0] == ~s_q.dir[WIDTH/2-1:0];
   endproperty
   a_nibble_lo: assert property (p_nibble_lo)
      else $error("lower pulldown mismatch");

   property p_lo_inh_off;
      @(posedge ref_clk) disable iff (!reset_n)
         s_q.inhibit[PCG_LOWER_INH_BIT]
            |-> pulldown_en[WIDTH/2-1:0] == '0;
   endproperty
   a_lo_inh_off: assert property (p_lo_inh_off)
      else $error("lower pulldown on while inhibited");

   property p_hi_inh_off;
      @(posedge ref_clk) disable iff (!reset_n)
         s_q.inhibit[PCG_UPPER_INH_BIT]
            |-> pulldown_en[WIDTH-1:WIDTH/2] == '0;
   endproperty
   a_hi_inh_off: assert property (p_hi_inh_off)
      else $error("upper pulldown on while inhibited");

   property p_mask_freeze;
      @(posedge ref_clk) disable iff (!reset_n)
         mask_pulldown_inhibit |=> s_q.inhibit == $past(s_q.inhibit);
   endproperty
   a_mask_freeze: assert property (p_mask_freeze)
      else $error("pulldown register changed under mask option");

   property p_reset_pd;
      @(posedge ref_clk) $rose(reset_n)
         |-> pulldown_en == {WIDTH{!mask_pulldown_inhibit}};
   endproperty
   a_reset_pd: assert property (p_reset_pd)
      else $error("pulldowns not enabled by reset");

   property p_dir_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         !(s_q.wr_pend && s_q.wr_addr == PCG_OFF_DIR)
            |=> s_q.dir == $past(s_q.dir);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction changed without a write");

   property p_inh_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         !(s_q.wr_pend && s_q.wr_addr == PCG_OFF_PULLDOWN)
            |=> s_q.inhibit == $past(s_q.inhibit);
   endproperty
   a_inh_hold: assert property (p_inh_hold)
      else $error("pulldown register changed without a write");

   property p_read_dir;
      @(posedge ref_clk) disable iff (!reset_n)
         (addr_valid && !hwrite && haddr == PCG_OFF_DIR)
            |=> hrdata == pcg_widen($past(s_q.dir));
   endproperty
   a_read_dir: assert property (p_read_dir)
      else $error("direction read value wrong");

   property p_read_pd;
      @(posedge ref_clk) disable iff (!reset_n)
         (addr_valid && !hwrite && haddr == PCG_OFF_PULLDOWN)
            |=> hrdata == PCG_UNDEF_READ;
   endproperty
   a_read_pd: assert property (p_read_pd)
      else $error("pulldown register read value wrong");

   property p_cov_write;
      @(posedge ref_clk) disable iff (!reset_n) addr_valid && hwrite;
   endproperty
   c_cov_write: cover property (p_cov_write);

   property p_cov_read;
      @(posedge ref_clk) disable iff (!reset_n) addr_valid && !hwrite;
   endproperty
   c_cov_read: cover property (p_cov_read);

   property p_cov_pd;
      @(posedge ref_clk) disable iff (!reset_n) pulldown_en != '0;
   endproperty
   c_cov_pd: cover property (p_cov_pd);

   property p_cov_mask_wr;
      @(posedge ref_clk) disable iff (!reset_n)
         mask_pulldown_inhibit && s_q.wr_pend &&
         s_q.wr_addr == PCG_OFF_PULLDOWN;
   endproperty
   c_cov_mask_wr: cover property (p_cov_mask_wr);

   property p_cov_mixed;
      @(posedge ref_clk) disable iff (!reset_n)
         addr_valid && !hwrite && haddr == PCG_OFF_LATCH &&
         s_q.dir != '0 && s_q.dir != '1;
   endproperty
   c_cov_mixed: cover property (p_cov_mixed);
endmodule : pcg_port

// ### testbench/pcg_board.sv
`timescale 1ns/10ps
module pcg_board
   import pcg_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pulldown_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_level
);
   logic [7:0] last_q;
   // a floating pin toggles every cycle so a stale level never passes
   always_ff @(posedge ref_clk) last_q <= pin_level;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_level[i] = pin_out[i];
         else if (ext_en[i]) pin_level[i] = ext_val[i];
         else if (pulldown_en[i]) pin_level[i] = 1'b0;
         else pin_level[i] = ~last_q[i];
      end
   end
endmodule : pcg_board

// ### testbench/port_c_gpio_with_pulldowns_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module port_c_gpio_with_pulldowns_tb;
   import pcg_pkg::*;
   logic ref_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, mask;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r;
   logic [7:0] pin_in, pin_out, pin_oe, pulldown_en, ext_en, ext_val;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   assign hready = hreadyout;
   pcg_port u_pcg_port (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .mask_pulldown_inhibit(mask),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pulldown_en(pulldown_en));
   pcg_board u_pcg_board (.ref_clk(ref_clk), .pin_out(pin_out),
      .pin_oe(pin_oe), .pulldown_en(pulldown_en), .ext_en(ext_en),
      .ext_val(ext_val), .pin_level(pin_in));
   // ---------------------------------------------------------------
   // clock, timeout, verdict
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // bus cycles; both end one edge after the data phase so that
   // register updates have landed when the caller looks
   // ---------------------------------------------------------------
   task automatic ahb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= PCG_HTRANS_NONSEQ;
      hsize <= 3'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge ref_clk);
   endtask : ahb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(a, 1'b1, d, q);
   endtask : wr
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
   endtask : do_reset
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {hsel, hwrite, mask, htrans, haddr, hsize} = '0;
      {hwdata, ext_en, ext_val} = '0;
      reset_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      ahb(PCG_OFF_DIR, 1'b0, 32'h0, r);
      `CHK(r, 32'h00000000)
      `CHK(pin_oe, 8'h00)
      `CHK(pulldown_en, 8'hFF)
      ahb(PCG_OFF_LATCH, 1'b0, 32'h0, r);
      `CHK(r, 32'h00000000)
      ext_en <= 8'hFF;
      ext_val <= 8'h3C;
      repeat (3) @(posedge ref_clk);
      ahb(PCG_OFF_LATCH, 1'b0, 32'h0, r);
      `CHK(r, 32'h0000003C)
      // latch set before the pins turn to outputs
      wr(PCG_OFF_LATCH, 32'h000000A5);
      `CHK(pin_out, 8'hA5)
      wr(PCG_OFF_DIR, 32'h000000F0);
      `CHK(pin_oe, 8'hF0)
      `CHK(pulldown_en, 8'h0F)
      ahb(PCG_OFF_DIR, 1'b0, 32'h0, r);
      `CHK(r, 32'h000000F0)
      repeat (3) @(posedge ref_clk);
      ahb(PCG_OFF_LATCH, 1'b0, 32'h0, r);
      `CHK(r, 32'h000000AC)
      // inhibits are clear before turning back to inputs
      wr(PCG_OFF_DIR, 32'h0);
      ext_en <= 8'h00;
      // plain writes only, never read-modify-write
      for (int k = 0; k < 4; k++) begin
         wr(PCG_OFF_PULLDOWN, 32'(k));
         `CHK(pulldown_en, {{4{~k[1]}}, {4{~k[0]}}})
      end
      ahb(PCG_OFF_PULLDOWN, 1'b0, 32'h0, r);
      `CHK(r, PCG_UNDEF_READ)
      ahb(12'hFFC, 1'b0, 32'h0, r);
      `CHK(r, 32'h00000000)
      do_reset();
      `CHK(pulldown_en, 8'hFF)
      `CHK(pin_out, 8'hA5)
      mask <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK(pulldown_en, 8'h00)
      wr(PCG_OFF_PULLDOWN, 32'h00000003);
      mask <= 1'b0;
      @(posedge ref_clk);
      `CHK(pulldown_en, 8'hFF)
      mask <= 1'b1;
      do_reset();
      `CHK(pulldown_en, 8'h00)
      wr(PCG_OFF_DIR, 32'h000000FF);
      ahb(PCG_OFF_LATCH, 1'b0, 32'h0, r);
      `CHK(r, 32'h000000A5)
      end_of_test();
   end
endmodule : port_c_gpio_with_pulldowns_tb
